// file: wsc_wake_regs.sv
// Purpose: Wake source control register bank behind the 16-bit serial port
// Assumes: Serial mode 0, LSB first; bits 6:0 address, bit 7 write, 15:8 data
// Notes: Serial pins are sampled by ref_clk through two-flop synchronisers
// Operation
// - Bit 7 of internal wake register enables second cyclic timer wake.
// - Bit 6 of internal wake register enables first cyclic timer wake.
// - Bit 2 turns watchdog off in stop mode; device may update it.
// - Reserved bits of all three registers always read zero.
// - Global interrupt bit zero: only wake events raise the interrupt.
// - Global interrupt bit one: any status event raises the interrupt.
// - Measurement selected: pins one and two never act as wake sources.
// - Measurement selected enables the measurement function in normal mode.
// - Measurement selector defaults to zero, pins one and two wake normally.
// - External register bits 2, 1, 0 enable wake pins three, two, one.
// - External register resets to 07; restart zeroes bits 6, 4, 3.
// - Fail-safe forces external register to x0x0 0111 and bus registers too.
// - Bias register holds pin three 5:4, pin two 3:2, pin one 1:0.
// - Bias codes: 00 none, 01 pull-down, 10 pull-up, 11 automatic.
// - Internal wake and bias registers reset to all zeros.
// - Transceiver mode 01 means wake capable, 00 off.
`timescale 1ns/1ps
module wsc_wake_regs
   import wsc_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Serial port pins
   input wire logic spi_clk,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe_n,
   // Device events and state
   input wire logic restart_evt,
   input wire logic failsafe_evt,
   input wire logic wd_stop_hw_we,
   input wire logic wd_stop_hw_val,
   input wire logic normal_mode,
   input wire logic wake_event,
   input wire logic status_event,
   input wire logic [1:0] bus_mode,
   // Configuration outputs
   output logic second_timer_wake_enable,
   output logic first_timer_wake_enable,
   output logic watchdog_off_in_stop,
   output logic measure_active,
   output logic int_request,
   output logic bus_wake_capable,
   output logic bus_failsafe_force,
   output logic [PIN_COUNT-1:0] pin_wake_active,
   output logic [PIN_COUNT-1:0] pin_pull_up,
   output logic [PIN_COUNT-1:0] pin_pull_down,
   output logic [PIN_COUNT-1:0] pin_bias_auto
);

   // ============================================================
   // Pin synchronisers
   logic [2:0] sync1_ff, sync2_ff, sync3_ff;
   logic [2:0] nxt_sync1, nxt_sync2, nxt_sync3;
   logic clk_s, cs_n_s, mosi_s, clk_rise, clk_fall, cs_fall, cs_rise;

   // Order is {clk, cs_n, mosi}; stage three only serves edge detection
   always_comb begin
      nxt_sync1 = {spi_clk, spi_cs_n, spi_mosi};
      nxt_sync2 = sync1_ff;
      nxt_sync3 = sync2_ff;
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         sync1_ff <= SYNC_IDLE;
         sync2_ff <= SYNC_IDLE;
         sync3_ff <= SYNC_IDLE;
      end else begin
         sync1_ff <= nxt_sync1;
         sync2_ff <= nxt_sync2;
         sync3_ff <= nxt_sync3;
      end
   end

   // Edges seen on synchronised levels only
   assign clk_s = sync2_ff[2];
   assign cs_n_s = sync2_ff[1];
   assign mosi_s = sync2_ff[0];
   assign clk_rise = clk_s & ~sync3_ff[2];
   assign clk_fall = ~clk_s & sync3_ff[2];
   assign cs_fall = ~cs_n_s & sync3_ff[1];
   assign cs_rise = cs_n_s & ~sync3_ff[1];

   // ============================================================
   // Register storage
   logic [7:0] int_wake_ff, ext_wake_ff, pin_bias_ff;
   logic [7:0] nxt_int_wake, nxt_ext_wake, nxt_pin_bias;
   logic [15:0] rx_ff, nxt_rx;
   logic [4:0] cnt_ff, nxt_cnt;
   logic [7:0] tx_ff, nxt_tx;
   logic miso_ff, nxt_miso, oe_n_ff, nxt_oe_n;
   logic write_go;

   // Read mux; masks keep reserved positions at zero
   function automatic logic [7:0] rd_mux(input logic [6:0] addr, input logic [7:0] iw,
                                         input logic [7:0] ew, input logic [7:0] pb);
      logic [7:0] val;
      val = 8'h00;
      case (addr)
         ADDR_INT_WAKE: val = iw & MASK_INT_WAKE;
         ADDR_EXT_WAKE: val = ew & MASK_EXT_WAKE;
         ADDR_PIN_BIAS: val = pb & MASK_PIN_BIAS;
         default: val = 8'h00;
      endcase
      return val;
   endfunction : rd_mux

   // ============================================================
   // Serial frame engine
   // The first byte out is zero; the addressed register follows once the
   // address is known, so a read answers in the same frame.
   always_comb begin
      nxt_rx = rx_ff;
      nxt_cnt = cnt_ff;
      nxt_tx = tx_ff;
      if (cs_fall) begin
         nxt_cnt = 5'h00;
         nxt_tx = 8'h00;
      end else if (!cs_n_s) begin
         if (clk_rise) begin
            nxt_rx = {mosi_s, rx_ff[15:1]};
            if (cnt_ff != CNT_MAX) begin
               nxt_cnt = cnt_ff + 5'h01;
            end
            if (cnt_ff == HALF_BITS - 5'h01) begin
               nxt_tx = rd_mux(rx_ff[15:9], int_wake_ff, ext_wake_ff, pin_bias_ff);
            end
         end else if (clk_fall && cnt_ff != HALF_BITS) begin
            nxt_tx = {1'b0, tx_ff[7:1]};
         end
      end
      nxt_miso = nxt_tx[0];
      nxt_oe_n = cs_n_s;
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rx_ff <= 16'h0000;
         cnt_ff <= 5'h00;
         tx_ff <= 8'h00;
         miso_ff <= 1'b0;
         oe_n_ff <= 1'b1;
      end else begin
         rx_ff <= nxt_rx;
         cnt_ff <= nxt_cnt;
         tx_ff <= nxt_tx;
         miso_ff <= nxt_miso;
         oe_n_ff <= nxt_oe_n;
      end
   end

   // Frames of any length but sixteen bits are dropped
   assign write_go = cs_rise & (cnt_ff == FRAME_BITS) & rx_ff[WR_BIT];

   // ============================================================
   // Register update
   // Priority: fail-safe over restart over host write; a hardware watchdog
   // update beats a host write landing in the same cycle.
   always_comb begin
      nxt_int_wake = int_wake_ff;
      nxt_ext_wake = ext_wake_ff;
      nxt_pin_bias = pin_bias_ff;
      if (write_go) begin
         case (rx_ff[6:0])
            ADDR_INT_WAKE: nxt_int_wake = rx_ff[15:8] & MASK_INT_WAKE;
            ADDR_EXT_WAKE: nxt_ext_wake = rx_ff[15:8] & MASK_EXT_WAKE;
            ADDR_PIN_BIAS: nxt_pin_bias = rx_ff[15:8] & MASK_PIN_BIAS;
            default: nxt_int_wake = int_wake_ff;
         endcase
      end
      if (restart_evt) begin
         nxt_ext_wake = ext_wake_ff & RESTART_KEEP;
      end
      if (failsafe_evt) begin
         nxt_ext_wake = (nxt_ext_wake & FS_KEEP) | FS_SET;
      end
      if (wd_stop_hw_we) begin
         nxt_int_wake[BIT_WD_OFF_STOP] = wd_stop_hw_val;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         int_wake_ff <= RST_INT_WAKE;
         ext_wake_ff <= RST_EXT_WAKE;
         pin_bias_ff <= RST_PIN_BIAS;
      end else begin
         int_wake_ff <= nxt_int_wake;
         ext_wake_ff <= nxt_ext_wake;
         pin_bias_ff <= nxt_pin_bias;
      end
   end

   // ============================================================
   // Per-pin decode
   logic [PIN_COUNT-1:0] act_w, pu_w, pd_w, auto_w;
   genvar gi;
   generate
      for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
         logic [1:0] bias;
         assign bias = pin_bias_ff[gi*BIAS_W +: BIAS_W];
         // Measurement borrows pins one and two, so their enables are ignored
         assign act_w[gi] = ext_wake_ff[gi] & ~(ext_wake_ff[BIT_MEASURE] & (gi < MEAS_PINS));
         assign pd_w[gi] = (bias == BIAS_DOWN);
         assign pu_w[gi] = (bias == BIAS_UP);
         assign auto_w[gi] = (bias == BIAS_AUTO);
      end
   endgenerate

   // ============================================================
   // Output registers
   logic [PIN_COUNT-1:0] act_ff, pu_ff, pd_ff, auto_ff;
   logic t2_ff, t1_ff, wd_ff, meas_ff, irq_ff, buswk_ff, fs_ff;
   logic nxt_t2, nxt_t1, nxt_wd, nxt_meas, nxt_irq, nxt_buswk, nxt_fs;

   always_comb begin
      nxt_t2 = int_wake_ff[BIT_SECOND_TIMER];
      nxt_t1 = int_wake_ff[BIT_FIRST_TIMER];
      nxt_wd = int_wake_ff[BIT_WD_OFF_STOP];
      nxt_meas = ext_wake_ff[BIT_MEASURE] & normal_mode;
      nxt_irq = wake_event | (ext_wake_ff[BIT_GLOBAL_INT] & status_event);
      nxt_buswk = (bus_mode == BUS_MODE_WAKE);
      nxt_fs = failsafe_evt;
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         t2_ff <= 1'b0;
         t1_ff <= 1'b0;
         wd_ff <= 1'b0;
         meas_ff <= 1'b0;
         irq_ff <= 1'b0;
         buswk_ff <= 1'b0;
         fs_ff <= 1'b0;
         act_ff <= '0;
         pu_ff <= '0;
         pd_ff <= '0;
         auto_ff <= '0;
      end else begin
         t2_ff <= nxt_t2;
         t1_ff <= nxt_t1;
         wd_ff <= nxt_wd;
         meas_ff <= nxt_meas;
         irq_ff <= nxt_irq;
         buswk_ff <= nxt_buswk;
         fs_ff <= nxt_fs;
         act_ff <= act_w;
         pu_ff <= pu_w;
         pd_ff <= pd_w;
         auto_ff <= auto_w;
      end
   end

   assign spi_miso = miso_ff;
   assign spi_miso_oe_n = oe_n_ff;
   assign second_timer_wake_enable = t2_ff;
   assign first_timer_wake_enable = t1_ff;
   assign watchdog_off_in_stop = wd_ff;
   assign measure_active = meas_ff;
   assign int_request = irq_ff;
   assign bus_wake_capable = buswk_ff;
   assign bus_failsafe_force = fs_ff;
   assign pin_wake_active = act_ff;
   assign pin_pull_up = pu_ff;
   assign pin_pull_down = pd_ff;
   assign pin_bias_auto = auto_ff;

   // ============================================================
   // Assertions
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   property p_reserved_zero;
      ((int_wake_ff & ~MASK_INT_WAKE) == 8'h00) && ((ext_wake_ff & ~MASK_EXT_WAKE) == 8'h00)
         && ((pin_bias_ff & ~MASK_PIN_BIAS) == 8'h00);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

   property p_reset_vals;
      $fell(reset) |-> (int_wake_ff == RST_INT_WAKE) && (ext_wake_ff == RST_EXT_WAKE) && (pin_bias_ff == RST_PIN_BIAS);
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");

   property p_failsafe;
      failsafe_evt |=> (ext_wake_ff[2:0] == 3'b111) && (ext_wake_ff[6] == 1'b0) && bus_failsafe_force;
   endproperty
   a_failsafe: assert property (p_failsafe) else $error("fail-safe value not forced");

   property p_measure_blocks;
      ext_wake_ff[BIT_MEASURE] |=> (pin_wake_active[1:0] == 2'b00);
   endproperty
   a_measure_blocks: assert property (p_measure_blocks) else $error("pin wake while measuring");

   property p_local_int;
      status_event && !wake_event && !ext_wake_ff[BIT_GLOBAL_INT] |=> !int_request;
   endproperty
   a_local_int: assert property (p_local_int) else $error("status raised interrupt");

   property p_global_int;
      (status_event && ext_wake_ff[BIT_GLOBAL_INT]) || wake_event |=> int_request;
   endproperty
   a_global_int: assert property (p_global_int) else $error("interrupt missing");

   property p_wd_hw;
      wd_stop_hw_we |=> (int_wake_ff[BIT_WD_OFF_STOP] == $past(wd_stop_hw_val)) ##1
         (watchdog_off_in_stop == $past(wd_stop_hw_val, 2));
   endproperty
   a_wd_hw: assert property (p_wd_hw) else $error("watchdog bit not updated");

   property p_ext_write;
      write_go && rx_ff[6:0] == ADDR_EXT_WAKE && !restart_evt && !failsafe_evt
         |=> ext_wake_ff == ($past(rx_ff[15:8]) & MASK_EXT_WAKE) ##1
         pin_wake_active[2] == $past(ext_wake_ff[2]);
   endproperty
   a_ext_write: assert property (p_ext_write) else $error("external write lost");

   property p_meas_normal;
      ext_wake_ff[BIT_MEASURE] && normal_mode |=> measure_active;
   endproperty
   a_meas_normal: assert property (p_meas_normal) else $error("measurement not active");

   c_write: cover property (write_go ##[1:40] cs_fall);
   c_failsafe: cover property (failsafe_evt ##1 bus_failsafe_force);
   c_meas: cover property (measure_active && wake_event);
   c_auto_bias: cover property (pin_bias_auto == 3'b111);

endmodule : wsc_wake_regs

// file: wsc_pkg.sv
// Purpose: Shared constants for the wake source control register bank
// Assumes: 8-bit registers reached over a 16-bit serial frame, LSB first
// Notes: Bus control force values are exported for the transceiver control block
// ============================================================
// Constants
package wsc_pkg;
   // Register addresses (7-bit frame address)
   localparam logic [6:0] ADDR_INT_WAKE = 7'h06;
   localparam logic [6:0] ADDR_EXT_WAKE = 7'h07;
   localparam logic [6:0] ADDR_PIN_BIAS = 7'h08;
   // Implemented bit masks; all other positions read zero
   localparam logic [7:0] MASK_INT_WAKE = 8'hC4;
   localparam logic [7:0] MASK_EXT_WAKE = 8'hA7;
   localparam logic [7:0] MASK_PIN_BIAS = 8'h3F;
   // Power-on / soft reset values
   localparam logic [7:0] RST_INT_WAKE = 8'h00;
   localparam logic [7:0] RST_EXT_WAKE = 8'h07;
   localparam logic [7:0] RST_PIN_BIAS = 8'h00;
   // Restart clears bits 6, 4 and 3 and keeps the rest
   localparam logic [7:0] RESTART_KEEP = 8'hA7;
   // Fail-safe: keep bits 7 and 5, zero 6/4/3, force 2:0 high
   localparam logic [7:0] FS_KEEP = 8'hA0;
   localparam logic [7:0] FS_SET = 8'h07;
   // Fail-safe values for the bus control registers (held outside)
   localparam logic [7:0] FS_BUS_CTRL1_SET = 8'h09;
   localparam logic [7:0] FS_BUS_CTRL1_KEEP = 8'hE0;
   localparam logic [7:0] FS_BUS_CTRL2 = 8'h01;
   // Field positions
   localparam int BIT_SECOND_TIMER = 7;
   localparam int BIT_FIRST_TIMER = 6;
   localparam int BIT_WD_OFF_STOP = 2;
   localparam int BIT_GLOBAL_INT = 7;
   localparam int BIT_MEASURE = 5;
   localparam int PIN_COUNT = 3;
   localparam int MEAS_PINS = 2;
   localparam int BIAS_W = 2;
   // Bias codes
   localparam logic [1:0] BIAS_NONE = 2'h0;
   localparam logic [1:0] BIAS_DOWN = 2'h1;
   localparam logic [1:0] BIAS_UP = 2'h2;
   localparam logic [1:0] BIAS_AUTO = 2'h3;
   // Transceiver mode codes
   localparam logic [1:0] BUS_MODE_OFF = 2'h0;
   localparam logic [1:0] BUS_MODE_WAKE = 2'h1;
   // Serial frame layout
   localparam logic [4:0] FRAME_BITS = 5'h10;
   localparam logic [4:0] HALF_BITS = 5'h08;
   localparam logic [4:0] CNT_MAX = 5'h1F;
   localparam int WR_BIT = 7;
   localparam logic [2:0] SYNC_IDLE = 3'h2;
endpackage : wsc_pkg

// file: wsc_host_model.sv
// Purpose: Host controller model that drives the 16-bit serial port of the wake register bank
// Assumes: Mode 0 framing, LSB first, link clock period 160 ns, phase unrelated to ref_clk
// Notes: The link clock stands low between frames; the data line shows the inverse of its last bit when deselected
`timescale 1ns/1ps
// ============================================================
// Host model
module wsc_host_model (
   // Serial port pins
   output logic spi_clk,
   output logic spi_cs_n,
   output logic spi_mosi,
   input wire logic spi_miso
);
   // Idle frame state at time zero
   initial begin
      spi_clk = 1'b0;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
   end

   // One frame: address, write flag and data out; reply byte back
   task automatic xfer(input logic [6:0] addr, input logic wr, input logic [7:0] wdata, output logic [7:0] rdata);
      logic [15:0] tx;
      logic [15:0] rx;
      tx = {wdata, wr, addr};
      rx = 16'h0000;
      spi_cs_n = 1'b0;
      // Odd lead-in keeps the link edges off the ref_clk grid
      #87;
      for (int i = 0; i < 16; i++) begin
         spi_mosi = tx[i];
         #80 spi_clk = 1'b1;
         // Reply bit is taken just before the fall, when it is settled
         #79 rx[i] = spi_miso;
         #1 spi_clk = 1'b0;
      end
      #80 spi_cs_n = 1'b1;
      // Released line must not keep showing the last bit
      spi_mosi = ~tx[15];
      #160;
      rdata = rx[15:8];
   endtask : xfer
endmodule : wsc_host_model

// file: wake_source_control_regs_test.sv
// Purpose: Self-checking bench for the wake source control register bank
// Assumes: Register updates land within 4 ref_clk cycles after a frame ends
// Notes: Table rows cover masked writes; awkward cases follow by hand
`timescale 1ns/1ps
// ============================================================
// Bench top
module wake_source_control_regs_test;
   import wsc_pkg::*;
   typedef struct packed {logic [6:0] addr; logic [7:0] wdata; logic [7:0] rexp;} wsc_row_t;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic spi_clk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe_n;
   logic restart_evt = 1'b0, failsafe_evt = 1'b0, wd_stop_hw_we = 1'b0, wd_stop_hw_val = 1'b0;
   logic normal_mode = 1'b0, wake_event = 1'b0, status_event = 1'b0;
   logic [1:0] bus_mode = 2'h0;
   logic second_timer_wake_enable, first_timer_wake_enable, watchdog_off_in_stop, measure_active;
   logic int_request, bus_wake_capable, bus_failsafe_force;
   logic [2:0] pin_wake_active, pin_pull_up, pin_pull_down, pin_bias_auto;
   int fail_count = 0;
   int total_checks = 0;
   logic [7:0] v;
   // Masked writes; the unmapped address must read back zero
   wsc_row_t rows [4] = '{'{7'h07, 8'hFF, 8'hA7}, '{7'h08, 8'hFF, 8'h3F}, '{7'h09, 8'hFF, 8'h00},
      '{7'h06, 8'hFF, 8'hC4}};

   // Clock at 50 MHz
   always #10 ref_clk = ~ref_clk;

   wsc_wake_regs u_dut (.ref_clk(ref_clk), .reset(reset), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
      .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n), .restart_evt(restart_evt),
      .failsafe_evt(failsafe_evt), .wd_stop_hw_we(wd_stop_hw_we), .wd_stop_hw_val(wd_stop_hw_val),
      .normal_mode(normal_mode), .wake_event(wake_event), .status_event(status_event), .bus_mode(bus_mode),
      .second_timer_wake_enable(second_timer_wake_enable), .first_timer_wake_enable(first_timer_wake_enable),
      .watchdog_off_in_stop(watchdog_off_in_stop), .measure_active(measure_active), .int_request(int_request),
      .bus_wake_capable(bus_wake_capable), .bus_failsafe_force(bus_failsafe_force),
      .pin_wake_active(pin_wake_active), .pin_pull_up(pin_pull_up), .pin_pull_down(pin_pull_down),
      .pin_bias_auto(pin_bias_auto));

   wsc_host_model u_host (.spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso));

   // ============================================================
   // Helpers
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // Step to just after a rising edge so drives never race the sampling edge
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : cyc

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] dummy;
      u_host.xfer(a, 1'b1, d, dummy);
      cyc(1);
   endtask : wr

   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      u_host.xfer(a, 1'b0, 8'h00, d);
      cyc(1);
   endtask : rd

   task automatic tally_and_finish();
      if (fail_count == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : tally_and_finish

   // Watchdog sized well beyond the roughly 65 us the sequence needs
   initial begin
      #500_000;
      fail_count++;
      tally_and_finish();
   end

   // ============================================================
   // Main sequence
   initial begin
      cyc(2);
      reset = 1'b0;
      cyc(4);
      chk({5'h00, pin_wake_active}, 8'h07);
      chk({7'h00, measure_active}, 8'h00);
      chk({7'h00, spi_miso_oe_n}, 8'h01);
      rd(7'h06, v);
      chk(v, 8'h00);
      rd(7'h07, v);
      chk(v, 8'h07);
      rd(7'h08, v);
      chk(v, 8'h00);
      // Table of masked writes, each read back
      foreach (rows[i]) begin
         wr(rows[i].addr, rows[i].wdata);
         rd(rows[i].addr, v);
         chk(v, rows[i].rexp);
      end
      chk({6'h00, second_timer_wake_enable, first_timer_wake_enable}, 8'h03);
      chk({7'h00, watchdog_off_in_stop}, 8'h01);
      chk({5'h00, pin_bias_auto}, 8'h07);
      chk({7'h00, measure_active}, 8'h00);
      // Measurement in normal mode masks pins one and two
      normal_mode = 1'b1;
      status_event = 1'b1;
      cyc(3);
      chk({7'h00, measure_active}, 8'h01);
      chk({5'h00, pin_wake_active}, 8'h04);
      chk({7'h00, int_request}, 8'h01);
      // Restart keeps every implemented bit
      restart_evt = 1'b1;
      cyc(1);
      restart_evt = 1'b0;
      rd(7'h07, v);
      chk(v, 8'hA7);
      // Scope bit cleared: a status event alone must not interrupt
      wr(7'h07, 8'h20);
      chk({7'h00, int_request}, 8'h00);
      wake_event = 1'b1;
      cyc(2);
      chk({7'h00, int_request}, 8'h01);
      wake_event = 1'b0;
      status_event = 1'b0;
      // Fail-safe entry forces the wake pin enable bits on and pulses the bus force
      failsafe_evt = 1'b1;
      cyc(1);
      failsafe_evt = 1'b0;
      chk({7'h00, bus_failsafe_force}, 8'h01);
      cyc(1);
      chk({7'h00, bus_failsafe_force}, 8'h00);
      rd(7'h07, v);
      chk(v, 8'h27);
      // Device-side update of the watchdog bit
      wd_stop_hw_we = 1'b1;
      cyc(1);
      wd_stop_hw_we = 1'b0;
      rd(7'h06, v);
      chk(v, 8'hC0);
      chk({7'h00, watchdog_off_in_stop}, 8'h00);
      wd_stop_hw_val = 1'b1;
      wd_stop_hw_we = 1'b1;
      cyc(1);
      wd_stop_hw_we = 1'b0;
      cyc(2);
      chk({7'h00, watchdog_off_in_stop}, 8'h01);
      // Bias codes per pin: auto, up, down and then none, down, up
      wr(7'h08, 8'h1B);
      chk({2'h0, pin_pull_up, pin_pull_down}, {2'h0, 3'h2, 3'h4});
      chk({5'h00, pin_bias_auto}, 8'h01);
      wr(7'h08, 8'h24);
      chk({2'h0, pin_pull_up, pin_pull_down}, {2'h0, 3'h4, 3'h2});
      chk({5'h00, pin_bias_auto}, 8'h00);
      // Pin enables with measurement off
      wr(7'h07, 8'h05);
      chk({5'h00, pin_wake_active}, 8'h05);
      wr(7'h07, 8'h02);
      chk({5'h00, pin_wake_active}, 8'h02);
      // Bench drives each transceiver mode code in turn
      for (int m = 0; m < 4; m++) begin
         bus_mode = 2'(m);
         cyc(2);
         chk({7'h00, bus_wake_capable}, (m == 1) ? 8'h01 : 8'h00);
      end
      // Mid-run reset brings every register back to its power-on value
      reset = 1'b1;
      cyc(2);
      reset = 1'b0;
      cyc(3);
      chk({5'h00, pin_wake_active}, 8'h07);
      rd(7'h06, v);
      chk(v, 8'h00);
      rd(7'h07, v);
      chk(v, 8'h07);
      // Output enable must be low while the frame is in flight
      fork
         rd(7'h08, v);
         begin
            cyc(20);
            chk({7'h00, spi_miso_oe_n}, 8'h00);
         end
      join
      chk(v, 8'h00);
      tally_and_finish();
   end
endmodule : wake_source_control_regs_test
